//--- hdl/cmreg_core.sv
// cmreg_core: programmer-visible register set with segment mapper and
// axi4-lite access to the mapping and interrupt registers
// assumes execution logic and memory interface on the same sys_clk
//
// Notes on behaviour
// - every 16-bit logical address yields a 20-bit physical address
// - four zones; root has no segment, the other three each own one
// - non-root upper physical bits = segment plus top logical nibble
// - boundary register is 8 bits holding two 4-bit boundary fields
// - each field is the top nibble where the next zone begins
// - far transfers give a full 20-bit address, bypassing zones
// - address fields, pc, sp and index registers are 16 bits wide
// - external vector base points to the external interrupt table
// - internal vector base points to the on-chip interrupt table
// - priority history holds four 2-bit priority fields
// - flags updated by alu; otherwise reached via accum-flag pair, and read in axi status
// - four unused flag bits store what a pop wrote
// - swap accum-flag exchanges the pair with its alternate at once
// - swap main pairs exchanges wide, second and third pairs together
// - 8-bit accumulator for bytes, wide pair for words, index may stand in
// - code window zone always spans 8k bytes
// - code window segment is 8 bits; far jumps, calls, returns set it
`timescale 1ns/1ps
module cmreg_core (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// axi4-lite write address
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// execution-side register port
	input  wire logic                 reg_wr,
	input  wire cmreg_pkg::cmreg_sel_t reg_wr_sel,
	input  wire logic [15:0]          reg_wr_data,
	input  wire cmreg_pkg::cmreg_sel_t reg_rd_sel,
	output logic [15:0]               reg_rd_data,
	// alu flag update
	input  wire logic                 flag_upd,
	input  wire logic [7:0]           flag_val,
	// alternate set exchanges
	input  wire logic                 swap_accum_flag,
	input  wire logic                 swap_main_pairs,
	// far jump, call and return
	input  wire logic                 far_jump,
	input  wire logic [7:0]           far_jump_seg,
	// priority history push and pop
	input  wire logic                 prio_push,
	input  wire logic [1:0]           prio_new,
	input  wire logic                 prio_pop,
	// interrupt vector pointers and current priority
	output logic [7:0]                ext_vector_base,
	output logic [7:0]                int_vector_base,
	output logic [1:0]                cur_priority,
	// address mapping
	input  wire logic [15:0]          logical_addr,
	input  wire logic                 far_address_transfer,
	input  wire logic [19:0]          far_addr,
	output logic [19:0]               phys_addr,
	output cmreg_pkg::cmreg_zone_t    phys_zone
);

	// main and alternate register set
	logic [7:0]  acc_q, acc_d, acc_alt_q, acc_alt_d;
	logic [7:0]  flags_q, flags_d, flags_alt_q, flags_alt_d;
	logic [15:0] wide_q, wide_d, wide_alt_q, wide_alt_d;
	logic [15:0] p2_q, p2_d, p2_alt_q, p2_alt_d;
	logic [15:0] p3_q, p3_d, p3_alt_q, p3_alt_d;
	logic [15:0] ix1_q, ix1_d, ix2_q, ix2_d;
	logic [15:0] sp_q, sp_d, pc_q, pc_d;
	logic [15:0] rd_q;

	// mapping and interrupt registers
	logic [7:0]  zcfg_q, dseg_q, sseg_q, cseg_q, evb_q, ivb_q, ph_q;

	// axi state
	logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [7:0]  wdata_q;
	logic        wlane_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// ---------------- execution-side register set ----------------

	// next state: exchanges first, then a write lands on the new main set
	always_comb begin
		acc_d       = acc_q;
		flags_d     = flags_q;
		acc_alt_d   = acc_alt_q;
		flags_alt_d = flags_alt_q;
		wide_d      = wide_q;
		wide_alt_d  = wide_alt_q;
		p2_d        = p2_q;
		p2_alt_d    = p2_alt_q;
		p3_d        = p3_q;
		p3_alt_d    = p3_alt_q;
		ix1_d       = ix1_q;
		ix2_d       = ix2_q;
		sp_d        = sp_q;
		pc_d        = pc_q;
		if (swap_accum_flag) begin
			acc_d       = acc_alt_q;
			flags_d     = flags_alt_q;
			acc_alt_d   = acc_q;
			flags_alt_d = flags_q;
		end
		if (swap_main_pairs) begin
			wide_d     = wide_alt_q;
			wide_alt_d = wide_q;
			p2_d       = p2_alt_q;
			p2_alt_d   = p2_q;
			p3_d       = p3_alt_q;
			p3_alt_d   = p3_q;
		end
		// alu touches only the defined flag bits
		if (flag_upd) begin
			flags_d = (flags_d & ~cmreg_pkg::FLAG_ALU_MASK) |
			          (flag_val & cmreg_pkg::FLAG_ALU_MASK);
		end
		if (reg_wr) begin
			case (reg_wr_sel)
				cmreg_pkg::SEL_ACC:        acc_d  = reg_wr_data[7:0];
				cmreg_pkg::SEL_WIDE:       wide_d = reg_wr_data;
				cmreg_pkg::SEL_PAIR_TWO:   p2_d   = reg_wr_data;
				cmreg_pkg::SEL_PAIR_THREE: p3_d   = reg_wr_data;
				cmreg_pkg::SEL_INDEX_ONE:  ix1_d  = reg_wr_data;
				cmreg_pkg::SEL_INDEX_TWO:  ix2_d  = reg_wr_data;
				cmreg_pkg::SEL_SP:         sp_d   = reg_wr_data;
				cmreg_pkg::SEL_PC:         pc_d   = reg_wr_data;
				cmreg_pkg::SEL_AF: begin
					// pop: all eight flag bits stored, spare ones included
					acc_d   = reg_wr_data[15:8];
					flags_d = reg_wr_data[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read mux; the accum-flag pair is the only selection here that exposes flags
	wire logic [15:0] rd_mux =
		(reg_rd_sel == cmreg_pkg::SEL_ACC)        ? {8'h00, acc_q} :
		(reg_rd_sel == cmreg_pkg::SEL_WIDE)       ? wide_q :
		(reg_rd_sel == cmreg_pkg::SEL_PAIR_TWO)   ? p2_q :
		(reg_rd_sel == cmreg_pkg::SEL_PAIR_THREE) ? p3_q :
		(reg_rd_sel == cmreg_pkg::SEL_INDEX_ONE)  ? ix1_q :
		(reg_rd_sel == cmreg_pkg::SEL_INDEX_TWO)  ? ix2_q :
		(reg_rd_sel == cmreg_pkg::SEL_SP)         ? sp_q :
		(reg_rd_sel == cmreg_pkg::SEL_PC)         ? pc_q :
		(reg_rd_sel == cmreg_pkg::SEL_AF)         ? {acc_q, flags_q} :
		                                            cmreg_pkg::RST_WORD;

	// register set flops
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			acc_q       <= cmreg_pkg::RST_BYTE;
			flags_q     <= cmreg_pkg::RST_BYTE;
			acc_alt_q   <= cmreg_pkg::RST_BYTE;
			flags_alt_q <= cmreg_pkg::RST_BYTE;
			wide_q      <= cmreg_pkg::RST_WORD;
			wide_alt_q  <= cmreg_pkg::RST_WORD;
			p2_q        <= cmreg_pkg::RST_WORD;
			p2_alt_q    <= cmreg_pkg::RST_WORD;
			p3_q        <= cmreg_pkg::RST_WORD;
			p3_alt_q    <= cmreg_pkg::RST_WORD;
			ix1_q       <= cmreg_pkg::RST_WORD;
			ix2_q       <= cmreg_pkg::RST_WORD;
			sp_q        <= cmreg_pkg::RST_WORD;
			pc_q        <= cmreg_pkg::RST_WORD;
			rd_q        <= cmreg_pkg::RST_WORD;
		end else begin
			acc_q       <= acc_d;
			flags_q     <= flags_d;
			acc_alt_q   <= acc_alt_d;
			flags_alt_q <= flags_alt_d;
			wide_q      <= wide_d;
			wide_alt_q  <= wide_alt_d;
			p2_q        <= p2_d;
			p2_alt_q    <= p2_alt_d;
			p3_q        <= p3_d;
			p3_alt_q    <= p3_alt_d;
			ix1_q       <= ix1_d;
			ix2_q       <= ix2_d;
			sp_q        <= sp_d;
			pc_q        <= pc_d;
			rd_q        <= rd_mux;
		end
	end

	assign reg_rd_data = rd_q;

	// ---------------- axi4-lite slave ----------------

	// address and data are taken independently, each held until paired
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;

	wire logic        aw_take  = s_axi_awvalid && s_axi_awready;
	wire logic        w_take   = s_axi_wvalid && s_axi_wready;
	wire logic        aw_have  = aw_hold_q || aw_take;
	wire logic        w_have   = w_hold_q || w_take;
	wire logic [7:0]  wa       = aw_hold_q ? awaddr_q : s_axi_awaddr;
	wire logic [7:0]  wd       = w_hold_q ? wdata_q : s_axi_wdata[7:0];
	wire logic        wl       = w_hold_q ? wlane_q : s_axi_wstrb[0];
	wire logic        wr_go    = aw_have && w_have && !bvalid_q;

	// write decode; only byte lane 0 carries register data
	wire logic        wr_zcfg  = wr_go && wl && (wa == cmreg_pkg::OFS_ZONE_CFG);
	wire logic        wr_dseg  = wr_go && wl && (wa == cmreg_pkg::OFS_DATA_SEG);
	wire logic        wr_sseg  = wr_go && wl && (wa == cmreg_pkg::OFS_STACK_SEG);
	wire logic        wr_cseg  = wr_go && wl && (wa == cmreg_pkg::OFS_CODE_SEG);
	wire logic        wr_evb   = wr_go && wl && (wa == cmreg_pkg::OFS_EXT_VEC);
	wire logic        wr_ivb   = wr_go && wl && (wa == cmreg_pkg::OFS_INT_VEC);
	wire logic        wr_ph    = wr_go && wl && (wa == cmreg_pkg::OFS_PRIO_HIST);
	wire logic        wa_ok    = (wa == cmreg_pkg::OFS_ZONE_CFG) ||
	                             (wa == cmreg_pkg::OFS_DATA_SEG) ||
	                             (wa == cmreg_pkg::OFS_STACK_SEG) ||
	                             (wa == cmreg_pkg::OFS_CODE_SEG) ||
	                             (wa == cmreg_pkg::OFS_EXT_VEC) ||
	                             (wa == cmreg_pkg::OFS_INT_VEC) ||
	                             (wa == cmreg_pkg::OFS_PRIO_HIST) ||
	                             (wa == cmreg_pkg::OFS_STATUS);

	// read decode; status shows live core state
	wire logic [7:0]  ra       = s_axi_araddr;
	wire logic [31:0] status   = {acc_q, flags_q, 6'h00, cur_priority, 6'h00, phys_zone};
	wire logic [31:0] rd_word  =
		(ra == cmreg_pkg::OFS_ZONE_CFG)  ? {24'h000000, zcfg_q} :
		(ra == cmreg_pkg::OFS_DATA_SEG)  ? {24'h000000, dseg_q} :
		(ra == cmreg_pkg::OFS_STACK_SEG) ? {24'h000000, sseg_q} :
		(ra == cmreg_pkg::OFS_CODE_SEG)  ? {24'h000000, cseg_q} :
		(ra == cmreg_pkg::OFS_EXT_VEC)   ? {24'h000000, evb_q} :
		(ra == cmreg_pkg::OFS_INT_VEC)   ? {24'h000000, ivb_q} :
		(ra == cmreg_pkg::OFS_PRIO_HIST) ? {24'h000000, ph_q} :
		(ra == cmreg_pkg::OFS_STATUS)    ? status :
		                                   32'h00000000;
	wire logic        ra_ok    = (ra <= cmreg_pkg::OFS_STATUS) && (ra[1:0] == 2'h0);

	// write channel holding and response
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= cmreg_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			aw_hold_q <= aw_have && !wr_go;
			w_hold_q  <= w_have && !wr_go;
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wa_ok ? cmreg_pkg::RESP_OKAY : cmreg_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= cmreg_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= ra_ok ? cmreg_pkg::RESP_OKAY : cmreg_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ---------------- mapping and interrupt registers ----------------

	// priority history: push shifts a new level in, pop restores the last
	wire logic [7:0] ph_push = {ph_q[7-cmreg_pkg::PRIO_W:0], prio_new};
	wire logic [7:0] ph_pop  = {ph_q[cmreg_pkg::PRIO_W-1:0], ph_q[7:cmreg_pkg::PRIO_W]};

	// core-side events win over a bus write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			zcfg_q <= cmreg_pkg::RST_ZONE_CFG;
			dseg_q <= cmreg_pkg::RST_SEG;
			sseg_q <= cmreg_pkg::RST_SEG;
			cseg_q <= cmreg_pkg::RST_SEG;
			evb_q  <= cmreg_pkg::RST_BYTE;
			ivb_q  <= cmreg_pkg::RST_BYTE;
			ph_q   <= cmreg_pkg::RST_PRIO_HIST;
		end else begin
			if (wr_zcfg) begin
				zcfg_q <= wd;
			end
			if (wr_dseg) begin
				dseg_q <= wd;
			end
			if (wr_sseg) begin
				sseg_q <= wd;
			end
			if (far_jump) begin
				cseg_q <= far_jump_seg;
			end else if (wr_cseg) begin
				cseg_q <= wd;
			end
			if (wr_evb) begin
				evb_q <= wd;
			end
			if (wr_ivb) begin
				ivb_q <= wd;
			end
			if (prio_push) begin
				ph_q <= ph_push;
			end else if (prio_pop) begin
				ph_q <= ph_pop;
			end else if (wr_ph) begin
				ph_q <= wd;
			end
		end
	end

	assign ext_vector_base = evb_q;
	assign int_vector_base = ivb_q;
	assign cur_priority    = ph_q[cmreg_pkg::PRIO_W-1:0];

	// address translation
	cmreg_mapper u_mapper (
		.sys_clk             (sys_clk),
		.nrst                (nrst),
		.logical_addr        (logical_addr),
		.far_valid           (far_address_transfer),
		.far_addr            (far_addr),
		.zone_boundary_cfg   (zcfg_q),
		.data_segment        (dseg_q),
		.stack_segment       (sseg_q),
		.code_window_segment (cseg_q),
		.phys_addr           (phys_addr),
		.zone                (phys_zone)
	);

endmodule

//--- hdl/cmreg_mapper.sv
// cmreg_mapper: 16-bit logical to 20-bit physical address translation
// assumes segment and boundary registers are held by the parent
`timescale 1ns/1ps
module cmreg_mapper (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// logical request
	input  wire logic [15:0]          logical_addr,
	input  wire logic                 far_valid,
	input  wire logic [19:0]          far_addr,
	// segment configuration
	input  wire logic [7:0]           zone_boundary_cfg,
	input  wire logic [7:0]           data_segment,
	input  wire logic [7:0]           stack_segment,
	input  wire logic [7:0]           code_window_segment,
	// physical result
	output logic [19:0]               phys_addr,
	output cmreg_pkg::cmreg_zone_t    zone
);

	wire logic [3:0]  nib       = logical_addr[15:12];
	wire logic [3:0]  data_bnd  = zone_boundary_cfg[cmreg_pkg::ZB_DATA_LSB +: 4];
	wire logic [3:0]  stack_bnd = zone_boundary_cfg[cmreg_pkg::ZB_STACK_LSB +: 4];

	// zone select: at or above a boundary belongs to the higher zone
	cmreg_pkg::cmreg_zone_t zone_sel;
	assign zone_sel = (nib >= cmreg_pkg::CODE_WIN_NIB) ? cmreg_pkg::ZONE_CODE :
	                  (nib >= stack_bnd) ? cmreg_pkg::ZONE_STACK :
	                  (nib >= data_bnd)  ? cmreg_pkg::ZONE_DATA :
	                                       cmreg_pkg::ZONE_ROOT;

	// segment of the selected zone; root has none
	wire logic [7:0] seg_sel = (zone_sel == cmreg_pkg::ZONE_CODE)  ? code_window_segment :
	                           (zone_sel == cmreg_pkg::ZONE_STACK) ? stack_segment :
	                           (zone_sel == cmreg_pkg::ZONE_DATA)  ? data_segment :
	                                                                 8'h00;

	// 8-bit add wraps modulo the 1m space by construction
	wire logic [7:0]  upper     = seg_sel + {4'h0, nib};
	wire logic [19:0] xlat      = {upper, logical_addr[11:0]};
	// far transfers bypass the zones entirely
	wire logic [19:0] phys_d    = far_valid ? far_addr : xlat;

	// registered so the memory interface sees a clean address
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			phys_addr <= 20'h00000;
			zone      <= cmreg_pkg::ZONE_ROOT;
		end else begin
			phys_addr <= phys_d;
			zone      <= zone_sel;
		end
	end

endmodule

//--- hdl/cmreg_pkg.sv
// cmreg_pkg: shared constants for the core register set and segment mapper
// assumes a 32-bit axi4-lite register bus and a single 100 MHz clock
package cmreg_pkg;

	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] OFS_ZONE_CFG   = 8'h00;
	localparam logic [7:0] OFS_DATA_SEG   = 8'h04;
	localparam logic [7:0] OFS_STACK_SEG  = 8'h08;
	localparam logic [7:0] OFS_CODE_SEG   = 8'h0c;
	localparam logic [7:0] OFS_EXT_VEC    = 8'h10;
	localparam logic [7:0] OFS_INT_VEC    = 8'h14;
	localparam logic [7:0] OFS_PRIO_HIST  = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1c;

	// axi response codes
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	// reset values
	localparam logic [7:0] RST_ZONE_CFG   = 8'h00;
	localparam logic [7:0] RST_SEG        = 8'h00;
	localparam logic [7:0] RST_PRIO_HIST  = 8'hff;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [15:0] RST_WORD      = 16'h0000;

	// flag bits driven by the alu; the other four are storage only
	localparam logic [7:0] FLAG_ALU_MASK  = 8'hc5;

	// code window always starts at logical e000, so it spans 8k bytes
	localparam logic [3:0] CODE_WIN_NIB   = 4'he;

	// zone boundary field positions
	localparam int ZB_DATA_LSB            = 0;
	localparam int ZB_STACK_LSB           = 4;

	// priority history field width
	localparam int PRIO_W                 = 2;

	typedef enum logic [1:0] {
		ZONE_ROOT,
		ZONE_DATA,
		ZONE_STACK,
		ZONE_CODE
	} cmreg_zone_t;

	// selector for the execution-side register port
	typedef enum logic [3:0] {
		SEL_ACC,
		SEL_WIDE,
		SEL_PAIR_TWO,
		SEL_PAIR_THREE,
		SEL_INDEX_ONE,
		SEL_INDEX_TWO,
		SEL_SP,
		SEL_PC,
		SEL_AF
	} cmreg_sel_t;

endpackage

//--- tb/cmreg_core_tb.sv
// cmreg_core_tb: tests for cmreg_core
// assumes a 100 MHz sys_clk
`timescale 1ns/1ps
module cmreg_core_tb;
	logic                   sys_clk = 1'b0;
	logic                   nrst = 1'b0;
	logic [7:0]             awaddr = 8'h00, araddr = 8'h00, fval = 8'h00;
	logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                   arvalid = 1'b0, rready = 1'b0, far = 1'b0;
	logic [31:0]            wdata = 32'h0, rv;
	logic [6:0]             strb = 7'h00;
	logic [15:0]            wval = 16'h0, laddr = 16'h0;
	logic [1:0]             resp;
	cmreg_pkg::cmreg_sel_t  wsel = cmreg_pkg::SEL_ACC, rsel = cmreg_pkg::SEL_ACC;
	wire logic              awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]        bresp, rresp, cprio;
	wire logic [31:0]       rdata;
	wire logic [15:0]       rd16;
	wire logic [7:0]        evb, ivb;
	wire logic [19:0]       paddr, seen_a;
	cmreg_pkg::cmreg_zone_t pzone, seen_z;
	int                     n_errors = 0, checks = 0;
	logic [31:0]            cfg [6] = '{32'hffffff84, 32'h10, 32'h20, 32'hf8, 32'h5a, 32'ha5};
	// strobes: wr, flag, swap af, swap main, far jump, push, pop
	always #5 sys_clk = ~sys_clk;
	cmreg_core uut (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.reg_wr(strb[0]), .reg_wr_sel(wsel), .reg_wr_data(wval), .reg_rd_sel(rsel),
		.reg_rd_data(rd16), .flag_upd(strb[1]), .flag_val(fval), .swap_accum_flag(strb[2]),
		.swap_main_pairs(strb[3]), .far_jump(strb[4]), .far_jump_seg(fval),
		.prio_push(strb[5]), .prio_new(fval[1:0]), .prio_pop(strb[6]),
		.ext_vector_base(evb), .int_vector_base(ivb), .cur_priority(cprio),
		.logical_addr(laddr), .far_address_transfer(far), .far_addr(20'habcde),
		.phys_addr(paddr), .phys_zone(pzone));
	cmreg_mem_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .phys_addr(paddr),
		.phys_zone(pzone), .seen_addr_q(seen_a), .seen_zone_q(seen_z));
	function automatic logic [19:0] xp(input logic [7:0] s, input logic [15:0] a);
		return {s + {4'h0, a[15:12]}, a[11:0]};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t response %h exp %h", $time, got, exp);
		end
	endtask
	// hung bus ends the run
	task automatic give_up();
		n_errors++;
		$display("CHECK FAILED t=%0t bus timeout", $time);
		wrap_up();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = cmreg_pkg::RESP_OKAY);
		bit done;
		done = 0;
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
		if (!done) give_up();
		chk_resp(resp, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = cmreg_pkg::RESP_OKAY);
		bit done;
		done = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rv = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
		if (!done) give_up();
		chk_val(rv, e, "read data");
		chk_resp(resp, er);
	endtask
	task automatic pulse(input logic [6:0] m, input logic [7:0] v);
		@(posedge sys_clk);
		strb <= m;
		fval <= v;
		@(posedge sys_clk);
		strb <= 7'h00;
	endtask
	task automatic wr_reg(input cmreg_pkg::cmreg_sel_t s, input logic [15:0] v);
		@(posedge sys_clk);
		wsel <= s;
		wval <= v;
		strb <= 7'h01;
		@(posedge sys_clk);
		strb <= 7'h00;
	endtask
	task automatic rd_reg(input cmreg_pkg::cmreg_sel_t s, input logic [15:0] e);
		@(posedge sys_clk);
		rsel <= s;
		@(posedge sys_clk);
		#1;
		chk_val({16'h0, rd16}, {16'h0, e}, "reg port");
	endtask
	// mapper and memory side add one edge each
	task automatic map(input logic [15:0] la, input logic f, input logic [19:0] e,
		input cmreg_pkg::cmreg_zone_t z);
		@(posedge sys_clk);
		laddr <= la;
		far <= f;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_val({12'h0, seen_a}, {12'h0, e}, "phys addr");
		if (!f) chk_val({30'h0, seen_z}, {30'h0, z}, "zone");
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		// mapped words 0x00..0x18 are consecutive
		for (int i = 0; i < 7; i++)
			axi_rd(8'(4 * i), (i == 6) ? 32'hff : 32'h0);
		axi_wr(cmreg_pkg::OFS_STATUS, 32'hffffffff);
		axi_rd(cmreg_pkg::OFS_STATUS, 32'h302);
		axi_rd(8'h20, 32'h0, cmreg_pkg::RESP_SLVERR);
		axi_rd(8'h02, 32'h0, cmreg_pkg::RESP_SLVERR);
		axi_wr(8'h20, 32'h1, cmreg_pkg::RESP_SLVERR);
		$display("test reset_and_map done");
		foreach (cfg[i])
			axi_wr(8'(4 * i), cfg[i]);
		axi_rd(cmreg_pkg::OFS_ZONE_CFG, 32'h84);
		chk_val({24'h0, evb}, 32'h5a, "ext vector");
		chk_val({24'h0, ivb}, 32'ha5, "int vector");
		$display("test config done");
		map(16'h3fff, 1'b0, xp(8'h00, 16'h3fff), cmreg_pkg::ZONE_ROOT);
		map(16'h4000, 1'b0, xp(8'h10, 16'h4000), cmreg_pkg::ZONE_DATA);
		map(16'h7abc, 1'b0, xp(8'h10, 16'h7abc), cmreg_pkg::ZONE_DATA);
		map(16'h8000, 1'b0, xp(8'h20, 16'h8000), cmreg_pkg::ZONE_STACK);
		map(16'hdfff, 1'b0, xp(8'h20, 16'hdfff), cmreg_pkg::ZONE_STACK);
		map(16'he000, 1'b0, xp(8'hf8, 16'he000), cmreg_pkg::ZONE_CODE);
		map(16'h1234, 1'b1, 20'habcde, cmreg_pkg::ZONE_ROOT);
		pulse(7'h10, 8'h44);
		axi_rd(cmreg_pkg::OFS_CODE_SEG, 32'h44);
		map(16'hffff, 1'b0, xp(8'h44, 16'hffff), cmreg_pkg::ZONE_CODE);
		$display("test mapping done");
		wr_reg(cmreg_pkg::SEL_AF, 16'ha5ff);
		rd_reg(cmreg_pkg::SEL_AF, 16'ha5ff);
		pulse(7'h02, 8'h00);
		rd_reg(cmreg_pkg::SEL_AF, {8'ha5, ~cmreg_pkg::FLAG_ALU_MASK});
		rd_reg(cmreg_pkg::SEL_ACC, 16'h00a5);
		pulse(7'h04, 8'h00);
		rd_reg(cmreg_pkg::SEL_AF, 16'h0000);
		pulse(7'h04, 8'h00);
		rd_reg(cmreg_pkg::SEL_AF, {8'ha5, ~cmreg_pkg::FLAG_ALU_MASK});
		$display("test flags done");
		for (int i = 1; i < 4; i++)
			wr_reg(cmreg_pkg::cmreg_sel_t'(i), 16'(16'h1111 * i));
		pulse(7'h08, 8'h00);
		for (int i = 1; i < 4; i++)
			rd_reg(cmreg_pkg::cmreg_sel_t'(i), 16'h0000);
		pulse(7'h08, 8'h00);
		for (int i = 1; i < 4; i++)
			rd_reg(cmreg_pkg::cmreg_sel_t'(i), 16'(16'h1111 * i));
		for (int i = 4; i < 8; i++) begin
			wr_reg(cmreg_pkg::cmreg_sel_t'(i), 16'(16'hbee0 + i));
			rd_reg(cmreg_pkg::cmreg_sel_t'(i), 16'(16'hbee0 + i));
		end
		$display("test pairs done");
		pulse(7'h20, 8'h01);
		#1;
		chk_val({30'h0, cprio}, 32'h1, "priority");
		pulse(7'h20, 8'h02);
		axi_rd(cmreg_pkg::OFS_PRIO_HIST, 32'hf6);
		pulse(7'h40, 8'h00);
		#1;
		chk_val({30'h0, cprio}, 32'h1, "priority");
		axi_rd(cmreg_pkg::OFS_PRIO_HIST, 32'hbd);
		$display("test priority done");
		wrap_up();
	end
endmodule

//--- tb/cmreg_mem_model.sv
// cmreg_mem_model: latches each physical address
// assumes a registered mapper output
`timescale 1ns/1ps
module cmreg_mem_model (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	// physical request from the mapper
	input  wire logic [19:0]            phys_addr,
	input  wire cmreg_pkg::cmreg_zone_t phys_zone,
	// captured request
	output logic [19:0]                 seen_addr_q,
	output cmreg_pkg::cmreg_zone_t      seen_zone_q
);
	// bank decode is not modelled
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			seen_addr_q <= 20'h00000;
			seen_zone_q <= cmreg_pkg::ZONE_ROOT;
		end else begin
			seen_addr_q <= phys_addr;
			seen_zone_q <= phys_zone;
		end
	end
endmodule

//--- tb/cmreg_props.sv
// cmreg_props: bus and mapping checks on cmreg_core
// assumes one sys_clk domain and a synchronous active-low nrst
`timescale 1ns/1ps
module cmreg_props (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// priority history
	input wire logic        prio_push,
	input wire logic [1:0]  prio_new,
	input wire logic [1:0]  cur_priority,
	// address mapping
	input wire logic [15:0] logical_addr,
	input wire logic        far_address_transfer,
	input wire logic [19:0] far_addr,
	input wire logic [19:0] phys_addr,
	input wire logic [1:0]  phys_zone
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// write and read takes
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("no write response");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("no read data");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata not held");
	a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_far_pass: assert property (far_address_transfer |=> phys_addr == $past(far_addr))
		else $error("far address lost");
	a_low_pass: assert property (!far_address_transfer |=> phys_addr[11:0] == $past(logical_addr[11:0]))
		else $error("low bits altered");
	a_code_zone: assert property (!far_address_transfer && logical_addr[15:12] >= 4'he |=> phys_zone == cmreg_pkg::ZONE_CODE)
		else $error("code zone missed");
	a_root_high: assert property (!far_address_transfer ##1 phys_zone == cmreg_pkg::ZONE_ROOT |-> phys_addr[19:12] == {4'h0, $past(logical_addr[15:12])})
		else $error("root offset");
	a_prio_top: assert property (prio_push |=> cur_priority == $past(prio_new))
		else $error("push not current");
endmodule
bind cmreg_core cmreg_props u_props (.*);
